/* include/npc_pkg.sv */
// package: constants and types for the normal-mode pulse counter core
package npc_pkg;
    localparam int          COUNT_W       = 32;
    localparam logic [31:0] LINEAR_MIN    = 32'h80000000;
    localparam logic [31:0] LINEAR_MAX    = 32'h7FFFFFFF;
    localparam logic [31:0] COUNT_RESET   = 32'h00000000;
    localparam logic [31:0] RING_LO_RESET = 32'h00000000;
    localparam logic [31:0] RING_HI_RESET = 32'h00000000;
    localparam int          RST_STAGES    = 2;

    typedef enum logic [1:0] {
        NPC_SRC_PHASE,
        NPC_SRC_INTCLK,
        NPC_SRC_OTHER_CH
    } npc_src_e;

    typedef enum logic {
        NPC_LINEAR,
        NPC_RING
    } npc_type_e;
endpackage : npc_pkg

/* include/npc_step_if.sv */
// interface: count step request between top and source selector
interface npc_step_if;
    logic up_step;
    logic down_step;
    modport sel (output up_step, output down_step);
    modport core (input up_step, input down_step);
endinterface : npc_step_if

/* verilog/npc_src_sel.sv */
// count source selector: turns the chosen source into up/down steps
module npc_src_sel
    import npc_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire npc_src_e src_sel,
    input  wire logic     phase_up,
    input  wire logic     phase_down,
    input  wire logic     intclk_tick,
    input  wire logic     other_coin_out,
    input  wire logic     other_ch_mode_ok,
    input  wire logic     count_down_cmd,
    npc_step_if.sel       step
);
    logic other_prev;
    logic next_other_prev;
    logic other_rise;

    always_comb begin
        next_other_prev = other_coin_out;
        other_rise      = other_coin_out & ~other_prev;
        step.up_step    = 1'b0;
        step.down_step  = 1'b0;
        unique case (src_sel)
            NPC_SRC_PHASE: begin
                step.up_step   = phase_up & ~phase_down;
                step.down_step = phase_down & ~phase_up;
            end
            NPC_SRC_INTCLK: begin
                step.up_step   = intclk_tick & ~count_down_cmd;
                step.down_step = intclk_tick & count_down_cmd;
            end
            NPC_SRC_OTHER_CH: begin
                // only a partner in normal or pwm mode may drive us
                step.up_step   = other_rise & other_ch_mode_ok & ~count_down_cmd; // R4
                step.down_step = other_rise & other_ch_mode_ok & count_down_cmd;  // R4
            end
            default: begin
                step.up_step   = 1'b0;
                step.down_step = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            other_prev <= 1'b0;
        end else begin
            other_prev <= next_other_prev;
        end
    end
endmodule : npc_src_sel

/* verilog/npc_core.sv */
// normal-mode pulse counter core: linear or ring 32-bit count
// Notes on behaviour
// (R1) linear type keeps count within -2147483648 to 2147483647
// (R2) ring type counts repeatedly between active lower and upper limits
// (R3) one counter type setting governs every counter feature of the mode
// (R4) other channel coincidence source only when that channel is normal or pwm
// (R5) phase inputs unused by the source are freed, never as interrupt inputs; the core frees only phase b
// (R6) z, function, latch and coincidence pins free when the function needs none
// (R7) linear down past minimum saturates and sets underflow flag
// (R8) ring up from upper limit minus one loads lower limit
// (R9) ring down from lower limit loads upper limit minus one
// (R10) new ring limits take effect on count enable rising edge only
// (R11) count is 32-bit two's complement, read as low and high words
module npc_core
    import npc_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    input  wire npc_src_e    src_sel_in,
    input  wire npc_type_e   counter_type_in,
    input  wire logic        phase_up_in,
    input  wire logic        phase_down_in,
    input  wire logic        phase_b_uses_in,
    input  wire logic        intclk_tick_in,
    input  wire logic        other_coin_out_in,
    input  wire logic        other_ch_mode_ok_in,
    input  wire logic        count_down_cmd_in,
    input  wire logic        count_enable_command_in,
    input  wire logic [31:0] ring_lower_in,
    input  wire logic [31:0] ring_upper_in,
    input  wire logic        aux_needed_in,
    output logic      [15:0] current_count_low_word_out,
    output logic      [15:0] current_count_high_word_out,
    output logic             underflow_detected_flag_out,
    output logic             overflow_detected_flag_out,
    output logic             counter_is_ring_out,
    output logic             phase_b_free_out,
    output logic             aux_pins_free_out
);
    logic [RST_STAGES-1:0] rst_sync;
    logic                  rst_n;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync <= '0;
        end else begin
            rst_sync <= {rst_sync[RST_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sync[RST_STAGES-1];

    npc_step_if step_bus ();

    npc_src_sel u_src (
        .clk              (core_clk_in),
        .rst_n            (rst_n),
        .src_sel          (src_sel_in),
        .phase_up         (phase_up_in),
        .phase_down       (phase_down_in),
        .intclk_tick      (intclk_tick_in),
        .other_coin_out   (other_coin_out_in),
        .other_ch_mode_ok (other_ch_mode_ok_in),
        .count_down_cmd   (count_down_cmd_in),
        .step             (step_bus.sel)
    );

    logic [31:0] count;
    logic [31:0] ring_lo;
    logic [31:0] ring_hi;
    logic        en_prev;
    logic        uflow;
    logic        oflow;
    logic        is_ring;
    logic        b_free;
    logic        aux_free;
    logic [31:0] next_count;
    logic [31:0] next_ring_lo;
    logic [31:0] next_ring_hi;
    logic        next_en_prev;
    logic        next_uflow;
    logic        next_oflow;
    logic        next_is_ring;
    logic        next_b_free;
    logic        next_aux_free;
    logic        en_rise;
    logic        up;
    logic        dn;

    always_comb begin
        next_count    = count;
        next_ring_lo  = ring_lo;
        next_ring_hi  = ring_hi;
        next_uflow    = uflow;
        next_oflow    = oflow;
        next_en_prev  = count_enable_command_in;
        en_rise       = count_enable_command_in & ~en_prev;
        up            = step_bus.up_step & count_enable_command_in;
        dn            = step_bus.down_step & count_enable_command_in;
        next_is_ring  = (counter_type_in == NPC_RING); // R3
        // phase b freed only when source ignores it; still no interrupt use
        next_b_free   = ~((src_sel_in == NPC_SRC_PHASE) & phase_b_uses_in); // R5
        next_aux_free = ~aux_needed_in; // R6
        if (en_rise) begin
            next_ring_lo = ring_lower_in; // R10
            next_ring_hi = ring_upper_in; // R10
        end
        if (counter_type_in == NPC_LINEAR) begin
            if (up) begin
                if (count == LINEAR_MAX) begin
                    next_oflow = 1'b1; // R1
                end else begin
                    next_count = count + 32'h00000001; // R1
                end
            end else if (dn) begin
                if (count == LINEAR_MIN) begin
                    next_uflow = 1'b1; // R7
                end else begin
                    next_count = count - 32'h00000001; // R1
                end
            end
        end else begin
            if (up) begin
                if (count == ring_hi - 32'h00000001) begin
                    next_count = ring_lo; // R8
                end else begin
                    next_count = count + 32'h00000001; // R2
                end
            end else if (dn) begin
                if (count == ring_lo) begin
                    next_count = ring_hi - 32'h00000001; // R9
                end else begin
                    next_count = count - 32'h00000001; // R2
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            count    <= COUNT_RESET;
            ring_lo  <= RING_LO_RESET;
            ring_hi  <= RING_HI_RESET;
            en_prev  <= 1'b0;
            uflow    <= 1'b0;
            oflow    <= 1'b0;
            is_ring  <= 1'b0;
            b_free   <= 1'b0;
            aux_free <= 1'b0;
        end else begin
            count    <= next_count;
            ring_lo  <= next_ring_lo;
            ring_hi  <= next_ring_hi;
            en_prev  <= next_en_prev;
            uflow    <= next_uflow;
            oflow    <= next_oflow;
            is_ring  <= next_is_ring;
            b_free   <= next_b_free;
            aux_free <= next_aux_free;
        end
    end

    // two's complement count split into words
    assign current_count_low_word_out  = count[15:0];  // R11
    assign current_count_high_word_out = count[31:16]; // R11
    assign underflow_detected_flag_out = uflow;
    assign overflow_detected_flag_out  = oflow;
    assign counter_is_ring_out         = is_ring;
    assign phase_b_free_out            = b_free;
    assign aux_pins_free_out           = aux_free;

    lin_sat_dn_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R7
        (counter_type_in == NPC_LINEAR && dn && count == LINEAR_MIN)
        |=> (count == LINEAR_MIN && uflow))
        else $error("linear down at minimum did not saturate");
    lin_sat_up_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R1
        (counter_type_in == NPC_LINEAR && up && count == LINEAR_MAX)
        |=> (count == LINEAR_MAX && oflow))
        else $error("linear up at maximum did not saturate");
    ring_wrap_up_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R8
        (counter_type_in == NPC_RING && up && count == ring_hi - 32'h00000001)
        |=> (count == $past(ring_lo)))
        else $error("ring up wrap did not load lower limit");
    ring_wrap_dn_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R9
        (counter_type_in == NPC_RING && dn && count == ring_lo)
        |=> (count == $past(ring_hi) - 32'h00000001))
        else $error("ring down wrap did not load upper limit minus one");
    ring_step_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R2
        (counter_type_in == NPC_RING && up && count != ring_hi - 32'h00000001)
        |=> (count == $past(count) + 32'h00000001))
        else $error("ring up step wrong");
    limit_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R10
        !en_rise |=> $stable(ring_lo) && $stable(ring_hi))
        else $error("ring limits changed without enable edge");
    limit_load_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R10
        en_rise |=> (ring_lo == $past(ring_lower_in) && ring_hi == $past(ring_upper_in)))
        else $error("ring limits not loaded on enable edge");
    other_src_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R4
        (src_sel_in == NPC_SRC_OTHER_CH && !other_ch_mode_ok_in) |=> $stable(count))
        else $error("count moved from disallowed other channel");
    type_flag_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R3
        1'b1 |=> (is_ring == ($past(counter_type_in) == NPC_RING)))
        else $error("counter type flag mismatch");
    words_a: assert property (@(posedge core_clk_in) disable iff (!rst_n) // R11
        {current_count_high_word_out, current_count_low_word_out} == count)
        else $error("count words do not match count");
endmodule : npc_core

/* verification/npc_pulse_src.sv */
// pulse source model: registers step requests onto the phase outputs one clock later
module npc_pulse_src (
    input  wire logic core_clk_in,
    input  wire logic up_req_in,
    input  wire logic down_req_in,
    output logic      phase_up_out,
    output logic      phase_down_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // decoder output copies the request level each clock, so a held request gives a held level
    initial begin
        phase_up_out = 1'b0;
        phase_down_out = 1'b0;
        forever begin
            @(posedge core_clk_in);
            phase_up_out <= up_req_in;
            phase_down_out <= down_req_in;
        end
    end
endmodule : npc_pulse_src

/* verification/npc_core_test.sv */
// testbench: normal-mode pulse counter core against a reference model
module npc_core_test
    import npc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, ureq, dreq, pu, pd, bu, tick, oc, mok, dcmd, en, aux, live;
    npc_src_e    src;
    npc_type_e   typ;
    logic [31:0] lo, hi, m_cnt, a_lo, a_hi;
    logic        m_uf, m_of, m_ring, m_ax, m_bf, p_en, p_oc, up, dn;
    logic [15:0] low, hiw;
    logic        uf, of, ring, bfree, afree;
    int          mismatches, num_checks, seed, i;
    npc_pulse_src u_src (.core_clk_in(clk), .up_req_in(ureq), .down_req_in(dreq),
        .phase_up_out(pu), .phase_down_out(pd));
    npc_core u_dut (.core_clk_in(clk), .resetn_in(rstn), .src_sel_in(src),
        .counter_type_in(typ), .phase_up_in(pu), .phase_down_in(pd), .phase_b_uses_in(bu),
        .intclk_tick_in(tick), .other_coin_out_in(oc), .other_ch_mode_ok_in(mok),
        .count_down_cmd_in(dcmd), .count_enable_command_in(en), .ring_lower_in(lo),
        .ring_upper_in(hi), .aux_needed_in(aux), .current_count_low_word_out(low),
        .current_count_high_word_out(hiw), .underflow_detected_flag_out(uf),
        .overflow_detected_flag_out(of), .counter_is_ring_out(ring),
        .phase_b_free_out(bfree), .aux_pins_free_out(afree));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {m_cnt, a_lo, a_hi} <= '0;
            {m_uf, m_of, m_ring, m_ax, m_bf, p_en, p_oc} <= '0;
        end else begin
            up = 1'b0;
            dn = 1'b0;
            case (src)
                NPC_SRC_PHASE: begin
                    up = pu & !pd;
                    dn = pd & !pu;
                end
                NPC_SRC_INTCLK: begin
                    up = tick & !dcmd;
                    dn = tick & dcmd;
                end
                default: begin
                    up = oc & !p_oc & mok & !dcmd;
                    dn = oc & !p_oc & mok & dcmd;
                end
            endcase
            up = up & en;
            dn = dn & en;
            if (en && !p_en) begin
                a_lo <= lo;
                a_hi <= hi;
            end
            if (typ == NPC_RING) begin
                if (up) m_cnt <= (m_cnt == a_hi - 32'h1) ? a_lo : m_cnt + 32'h1;
                if (dn) m_cnt <= (m_cnt == a_lo) ? a_hi - 32'h1 : m_cnt - 32'h1;
            end else begin
                if (up && m_cnt == LINEAR_MAX) m_of <= 1'b1;
                else if (up) m_cnt <= m_cnt + 32'h1;
                if (dn && m_cnt == LINEAR_MIN) m_uf <= 1'b1;
                else if (dn) m_cnt <= m_cnt - 32'h1;
            end
            {p_en, p_oc, m_ring, m_ax} <= {en, oc, typ == NPC_RING, !aux};
            // phase b is only taken when the phase source uses it
            m_bf <= !(bu && src == NPC_SRC_PHASE);
        end
    end
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    always @(negedge clk) begin
        if (live) begin
            chk({hiw, low, uf, of, ring, afree}, {m_cnt, m_uf, m_of, m_ring, m_ax});
            chk({35'h0, bfree}, {35'h0, m_bf});
        end
    end
    task automatic pulse(input logic u, input logic d);
        ureq <= u;
        dreq <= d;
        @(posedge clk);
        {ureq, dreq} <= 2'b00;
        @(posedge clk);
    endtask : pulse
    task automatic arm(input logic [31:0] l, input logic [31:0] h);
        en <= 1'b0;
        @(posedge clk);
        {lo, hi, en} <= {l, h, 1'b1};
        repeat (2) @(posedge clk);
    endtask : arm
    task automatic tally_and_finish;
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {rstn, ureq, dreq, bu, tick, oc, mok, dcmd, en, aux, live} = '0;
        {lo, hi, mismatches, num_checks} = '0;
        src = NPC_SRC_PHASE;
        typ = NPC_LINEAR;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        live <= 1'b1;
        seed = $urandom(32'h714e7aa9);
        typ <= NPC_RING;
        arm(32'h00000000, 32'h80000000);
        pulse(1'b0, 1'b1);
        typ <= NPC_LINEAR;
        repeat (2) pulse(1'b1, 1'b0);
        typ <= NPC_RING;
        pulse(1'b1, 1'b0);
        arm(32'h80000000, 32'h00000001);
        pulse(1'b1, 1'b0);
        typ <= NPC_LINEAR;
        repeat (2) pulse(1'b0, 1'b1);
        typ <= NPC_RING;
        // small ring around the count, so the old limits must wrap it
        arm(32'h80000000, 32'h80000004);
        {lo, hi} <= {32'h00000005, 32'h00000008};
        for (i = 0; i < 12; i++) pulse(1'b1, 1'b0);
        arm(32'h00000005, 32'h00000008);
        for (i = 0; i < 6; i++) pulse(i > 2, i <= 2);
        pulse(1'b1, 1'b1);
        en <= 1'b0;
        pulse(1'b1, 1'b0);
        src <= NPC_SRC_INTCLK;
        en <= 1'b1;
        for (i = 0; i < 4; i++) begin
            {tick, dcmd} <= {1'b1, i[1]};
            @(posedge clk);
        end
        tick <= 1'b0;
        src <= NPC_SRC_OTHER_CH;
        for (i = 0; i < 24; i++) begin
            {mok, dcmd, oc} <= {i[4:3], i[2]};
            @(posedge clk);
        end
        oc <= 1'b0;
        src <= NPC_SRC_PHASE;
        typ <= NPC_LINEAR;
        repeat (3) @(posedge clk);
        live <= 1'b1;
        for (i = 0; i < 400; i++) begin
            {ureq, dreq, tick, dcmd, bu, aux} <= 6'($urandom);
            en <= ($urandom_range(7, 0) != 0);
            src <= npc_src_e'($urandom_range(1, 0));
            @(posedge clk);
        end
        tally_and_finish();
    end
endmodule : npc_core_test
